// ===== pkg/stdc_pkg.sv
`default_nettype none
package stdc_pkg;
  localparam int COUNT_WIDTH = 24;
  localparam logic [23:0] COUNT_ZERO = 24'h000000;
  localparam logic [23:0] COUNT_ONE = 24'h000001;
  localparam logic [23:0] RELOAD_RESET = 24'h000000;
  localparam logic FLAG_RESET = 1'h0;
  localparam logic ENABLE_RESET = 1'h0;
endpackage
`default_nettype wire

// ===== src/stdc_tick_counter.sv
// Operation
// - 24-bit down counter wrapping at zero
// - enabled: decrement count each clock
// - after zero, load reload value next edge
// - enabled decrement from one to zero sets wrap flag
// - reading flag register clears the flag unless a wrap sets it in the same cycle
// - any count write clears count to zero
// - count value unspecified after reset
// - zero reload holds count at zero
`timescale 1ns/10ps
`default_nettype none
module stdc_tick_counter
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic reload_write,
  input wire logic [23:0] reload_write_data,
  input wire logic count_write,
  input wire logic flag_read,
  output logic [23:0] reload_value_register,
  output logic [23:0] current_count_register,
  output logic wrapped_to_zero_flag
);

  logic [23:0] next_count;
  logic hit_zero;

  function automatic logic [23:0] stdc_decrement(input logic [23:0] value);
    stdc_decrement = value - stdc_pkg::COUNT_ONE;
  endfunction

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      reload_value_register <= stdc_pkg::RELOAD_RESET;
    else if (reload_write)
      reload_value_register <= reload_write_data;
  end

  always_comb
  begin
    next_count = current_count_register;
    hit_zero = 1'h0;
    if (count_write)
      next_count = stdc_pkg::COUNT_ZERO;
    else if (enable)
    begin
      if (current_count_register == stdc_pkg::COUNT_ZERO)
        next_count = reload_value_register;
      else
      begin
        next_count = stdc_decrement(current_count_register);
        hit_zero = (current_count_register == stdc_pkg::COUNT_ONE);
      end
    end
  end

  // count has no reset: its value is undefined after reset
  always_ff @(posedge core_clk)
  begin
    current_count_register <= next_count;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      wrapped_to_zero_flag <= stdc_pkg::FLAG_RESET;
    else if (hit_zero)
      wrapped_to_zero_flag <= 1'h1;
    else if (flag_read)
      wrapped_to_zero_flag <= 1'h0;
  end

  property p_decrement;
    @(posedge core_clk) disable iff (reset)
    (enable && !count_write && current_count_register != 24'h000000)
    |=> current_count_register == $past(current_count_register) - 24'h000001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not decrement");

  property p_reload;
    @(posedge core_clk) disable iff (reset)
    (enable && !count_write && current_count_register == 24'h000000)
    |=> current_count_register == $past(reload_value_register);
  endproperty
  a_reload: assert property (p_reload) else $error("count did not reload");

  property p_flag_set;
    @(posedge core_clk) disable iff (reset)
    (enable && !count_write && current_count_register == 24'h000001) |=> wrapped_to_zero_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set at zero");

  property p_flag_clear;
    @(posedge core_clk) disable iff (reset)
    (flag_read && wrapped_to_zero_flag && !hit_zero) |=> !wrapped_to_zero_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by read");

  property p_write_clears;
    @(posedge core_clk) disable iff (reset)
    count_write |=> current_count_register == 24'h000000;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("count write did not clear");

  property p_zero_hold;
    @(posedge core_clk) disable iff (reset)
    (enable && !count_write && !reload_write && current_count_register == 24'h000000
      && reload_value_register == 24'h000000) [*2] |=> current_count_register == 24'h000000;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero reload did not hold");

  property p_disabled_hold;
    @(posedge core_clk) disable iff (reset)
    (!enable && !count_write) |=> $stable(current_count_register) && !$rose(wrapped_to_zero_flag);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("count moved while disabled");

  property p_reload_write;
    @(posedge core_clk) disable iff (reset)
    (reload_write && !count_write && !enable) |=> $stable(current_count_register);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("reload write moved count");

  property p_wrap_range;
    @(posedge core_clk) disable iff (reset)
    (enable && !count_write && current_count_register == 24'h000000
      && reload_value_register == 24'hFFFFFF) |=> current_count_register == 24'hFFFFFF;
  endproperty
  a_wrap_range: assert property (p_wrap_range) else $error("full reload wrong");

  // consecutive edges parked at zero by a zero reload
  logic [2:0] zero_run;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      zero_run <= 3'h0;
    else if (enable && !count_write && current_count_register == stdc_pkg::COUNT_ZERO
      && reload_value_register == stdc_pkg::COUNT_ZERO)
      zero_run <= (zero_run == 3'h7) ? zero_run : zero_run + 3'h1;
    else
      zero_run <= 3'h0;
  end

  property p_zero_run;
    @(posedge core_clk) disable iff (reset)
    (zero_run >= 3'h2)
    |-> current_count_register == stdc_pkg::COUNT_ZERO && !$rose(wrapped_to_zero_flag);
  endproperty
  a_zero_run: assert property (p_zero_run) else $error("parked count moved");

  property p_flag_sticky;
    @(posedge core_clk) disable iff (reset)
    (!hit_zero && !flag_read)
    |=> $stable(wrapped_to_zero_flag);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag changed without cause");

  property p_flag_rise_zero;
    @(posedge core_clk) disable iff (reset)
    $rose(wrapped_to_zero_flag)
    |-> current_count_register == stdc_pkg::COUNT_ZERO;
  endproperty
  a_flag_rise_zero: assert property (p_flag_rise_zero) else $error("flag rose away from zero");

  property p_set_beats_read;
    @(posedge core_clk) disable iff (reset)
    (hit_zero && flag_read)
    |=> wrapped_to_zero_flag;
  endproperty
  a_set_beats_read: assert property (p_set_beats_read) else $error("read cleared a new wrap");

  property p_write_no_flag;
    @(posedge core_clk) disable iff (reset)
    (count_write && !wrapped_to_zero_flag)
    |=> !wrapped_to_zero_flag;
  endproperty
  a_write_no_flag: assert property (p_write_no_flag) else $error("count write set flag");

  property p_flag_fall_read;
    @(posedge core_clk) disable iff (reset)
    $fell(wrapped_to_zero_flag)
    |-> $past(flag_read);
  endproperty
  a_flag_fall_read: assert property (p_flag_fall_read) else $error("flag cleared without read");

  property p_reload_load;
    @(posedge core_clk) disable iff (reset)
    reload_write
    |=> reload_value_register == $past(reload_write_data);
  endproperty
  a_reload_load: assert property (p_reload_load) else $error("reload write lost");

  property p_reload_keep;
    @(posedge core_clk) disable iff (reset)
    !reload_write
    |=> $stable(reload_value_register);
  endproperty
  a_reload_keep: assert property (p_reload_keep) else $error("reload changed without write");

  property p_reload_enabled;
    @(posedge core_clk) disable iff (reset)
    (reload_write && enable && !count_write && current_count_register != stdc_pkg::COUNT_ZERO)
    |=> current_count_register == $past(current_count_register) - stdc_pkg::COUNT_ONE;
  endproperty
  a_reload_enabled: assert property (p_reload_enabled) else $error("reload write disturbed count");

  property p_count_cause;
    @(posedge core_clk) disable iff (reset)
    ($changed(current_count_register) && !$past(count_write))
    |-> $past(enable);
  endproperty
  a_count_cause: assert property (p_count_cause) else $error("count moved while disabled");

  c_wrap: cover property (@(posedge core_clk) disable iff (reset) hit_zero ##1 wrapped_to_zero_flag);
  c_read_clear: cover property (@(posedge core_clk) disable iff (reset)
    wrapped_to_zero_flag && flag_read ##1 !wrapped_to_zero_flag);
  c_clear_write: cover property (@(posedge core_clk) disable iff (reset) count_write && enable);
  c_set_beats_read: cover property (@(posedge core_clk) disable iff (reset) hit_zero && flag_read);
  c_reload_change: cover property (@(posedge core_clk) disable iff (reset)
    reload_write && enable && current_count_register != stdc_pkg::COUNT_ZERO);

endmodule
`default_nettype wire

// ===== dv/stdc_tick_counter_tb.sv
`timescale 1ns/10ps
`default_nettype none
module stdc_tick_counter_tb;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic enable = 1'h0;
  logic reload_write = 1'h0;
  logic [23:0] reload_write_data = 24'h000000;
  logic count_write = 1'h0;
  logic flag_read = 1'h0;
  logic [23:0] reload_value_register;
  logic [23:0] current_count_register;
  logic wrapped_to_zero_flag;
  logic [23:0] exp_reload = 24'h000000;
  int err_count = 0;
  int total_checks = 0;
  always #25 core_clk = ~core_clk;
  stdc_tick_counter u_dut (.core_clk(core_clk), .reset(reset), .enable(enable), .reload_write(reload_write),
    .reload_write_data(reload_write_data), .count_write(count_write), .flag_read(flag_read),
    .reload_value_register(reload_value_register), .current_count_register(current_count_register),
    .wrapped_to_zero_flag(wrapped_to_zero_flag));
  // ctl is {enable, reload_write, count_write, flag_read}; inputs move 1 ns after the edge
  task automatic step(input logic [3:0] ctl, input logic [23:0] d, input logic [23:0] ec, input logic ef);
    begin
      {enable, reload_write, count_write, flag_read} = ctl;
      reload_write_data = d;
      if (ctl[2])
        exp_reload = d;
      @(posedge core_clk);
      #1;
      total_checks++;
      if ((current_count_register !== ec) || (wrapped_to_zero_flag !== ef) || (reload_value_register !== exp_reload))
      begin
        err_count++;
        $display("MISMATCH t=%0t count=%h flag=%b reload=%h", $time, current_count_register,
          wrapped_to_zero_flag, reload_value_register);
      end
    end
  endtask
  task automatic summarize();
    begin
      $display("errors=%0d checks=%0d", err_count, total_checks);
      if ((err_count == 0) && (total_checks > 0))
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    #5000;
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'h0;
    step(4'h2, 24'h000000, 24'h000000, 1'h0);
    step(4'h4, 24'h000003, 24'h000000, 1'h0);
    step(4'h8, 24'h000000, 24'h000003, 1'h0);
    step(4'h8, 24'h000000, 24'h000002, 1'h0);
    step(4'h8, 24'h000000, 24'h000001, 1'h0);
    step(4'h8, 24'h000000, 24'h000000, 1'h1);
    step(4'h9, 24'h000000, 24'h000003, 1'h0);
    step(4'h0, 24'h000000, 24'h000003, 1'h0);
    step(4'hA, 24'h000000, 24'h000000, 1'h0);
    step(4'h8, 24'h000000, 24'h000003, 1'h0);
    step(4'h8, 24'h000000, 24'h000002, 1'h0);
    step(4'h8, 24'h000000, 24'h000001, 1'h0);
    step(4'h9, 24'h000000, 24'h000000, 1'h1);
    step(4'h4, 24'hFFFFFF, 24'h000000, 1'h1);
    step(4'h9, 24'h000000, 24'hFFFFFF, 1'h0);
    step(4'h8, 24'h000000, 24'hFFFFFE, 1'h0);
    step(4'hC, 24'h000002, 24'hFFFFFD, 1'h0);
    step(4'hA, 24'h000000, 24'h000000, 1'h0);
    step(4'h8, 24'h000000, 24'h000002, 1'h0);
    step(4'h6, 24'h000000, 24'h000000, 1'h0);
    step(4'h8, 24'h000000, 24'h000000, 1'h0);
    step(4'h8, 24'h000000, 24'h000000, 1'h0);
    step(4'h8, 24'h000000, 24'h000000, 1'h0);
    summarize();
  end
endmodule
`default_nettype wire
